/* hw/lscr_pkg.sv */
// Constants and carrier types for the line sensor chain readout
// Summary of operation
// - Gain select high picks 0.5 pF high gain; low picks 1 pF low gain.
// - In the 256 variant, the first section gives low channels, the second 129-256.
// - Serially chained sections put channels 1 to 256 in order on one line.
// - Parallel 256 variant: both sections lead, each giving 128 channels at once.
// - Timing starts at the first falling sensor clock after reset goes low.
// - First channel valid 18.5 to 20.5 clocks from start, then every 4 clocks.
// - Sample trigger rises at 19.5 clocks, then every 4 clocks.
package lscr_pkg;

  // Elements of one section; the 256 variant is two sections of this size
  localparam int unsigned        SECT_ELEMS      = 128;
  localparam logic [8:0]         SECOND_BASE     = 9'h080;
  // Times in sensor clocks, doubled to half-clock units
  localparam real                VID_START_CLK   = 18.5;
  localparam real                VID_END_CLK     = 20.5;
  localparam real                TRIG_RISE_CLK   = 19.5;
  localparam int unsigned        CHAN_PERIOD_CLK = 4;
  localparam logic [11:0]        VID_START_H     = 12'(int'(VID_START_CLK * 2.0));
  localparam logic [2:0]         VID_LEN_H       = 3'(int'((VID_END_CLK - VID_START_CLK) * 2.0));
  localparam logic [2:0]         TRIG_OFS_H      = 3'(int'((TRIG_RISE_CLK - VID_START_CLK) * 2.0));
  localparam logic [11:0]        CHAN_PERIOD_H   = 12'(CHAN_PERIOD_CLK * 2);
  localparam logic [11:0]        SCAN_LEN_H      = 12'(SECT_ELEMS * CHAN_PERIOD_CLK * 2);
  localparam logic [11:0]        DONE_LEN_H      = 12'h0002;
  localparam logic [11:0]        START_H         = 12'h0002;

  typedef enum logic [1:0] {LSCR_IDLE, LSCR_ARMED, LSCR_RUN, LSCR_DONE} lscr_mode_t;

  typedef struct packed {
    logic       trig;
    logic       scan_done_n;
    logic       video_en;
    logic [8:0] channel;
    logic       feedback_cap;
  } lscr_out_t;

  typedef struct packed {
    lscr_mode_t  mode;
    logic [11:0] hcnt;
    logic        clk_prev;
    logic        start_seen;
    lscr_out_t   out;
  } lscr_state_t;

endpackage : lscr_pkg

/* hw/lscr_sync.sv */
// Two-stage synchroniser for one asynchronous pin
`timescale 1ns/1ns
module lscr_sync
  import lscr_pkg::*;
(
  input  wire logic mclk,    // System clock
  input  wire logic sys_rst, // Synchronous reset
  input  wire logic async_i, // Pin level
  output logic      sync_o   // Synchronised level
);

  logic meta_q;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : lscr_sync

/* hw/lscr_top.sv */
// Self-timed readout sequencer of one photodiode array section
`timescale 1ns/1ns
module lscr_top
  import lscr_pkg::*;
(
  input  wire logic mclk,           // 250 MHz system clock
  input  wire logic sys_rst,        // Synchronous reset, active high
  input  wire logic sensor_clk,     // Sensor clock pin
  input  wire logic sensor_rst,     // Sensor reset pin, active high
  input  wire logic ext_start_in,   // External start pin, active low pulse
  input  wire logic lead_sel,       // Strap: 1 leads, 0 follows
  input  wire logic gain_sel,       // Strap: 1 high gain, 0 low gain
  input  wire logic second_section, // Strap: 1 for second half section
  output logic      trig,           // Sample trigger
  output logic      scan_done_n,    // End of scan, active low
  output logic      video_en,       // Video driven and valid
  output logic [8:0] channel,       // Channel on video, 1-based
  output logic      feedback_cap    // 1 selects 0.5 pF, 0 selects 1 pF
);

  localparam int unsigned NPINS = 6;

  logic [NPINS-1:0] pin_raw;
  logic [NPINS-1:0] pin_s;
  lscr_state_t      s_q;
  lscr_state_t      s_d;
  logic             clk_s;
  logic             rst_s;
  logic             start_s;
  logic             lead_s;
  logic             gain_s;
  logic             sect_s;
  logic             clk_fall;
  logic             clk_edge;
  logic [11:0]      rel;
  logic [8:0]       idx;

  // Start pin idles high; inverted so the synchroniser reset value means no start
  assign pin_raw = {sensor_clk, sensor_rst, ~ext_start_in, lead_sel, gain_sel, second_section};
  assign {clk_s, rst_s, start_s, lead_s, gain_s, sect_s} = pin_s;

  // Every pin comes from outside the mclk domain
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++)
    begin : g_sync
      lscr_sync u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .async_i (pin_raw[gi]),
        .sync_o  (pin_s[gi])
      );
    end
  endgenerate

  assign clk_fall = s_q.clk_prev & ~clk_s;
  assign clk_edge = s_q.clk_prev ^ clk_s;
  assign rel      = s_q.hcnt - VID_START_H;
  assign idx      = 9'(rel >> 3);

  always_comb
  begin
    s_d          = s_q;
    s_d.clk_prev = clk_s;
    s_d.out.feedback_cap = gain_s;
    unique case (s_q.mode)
      LSCR_IDLE:
      begin
        s_d.start_seen = 1'b0;
        if (!rst_s)
          s_d.mode = LSCR_ARMED;
      end
      LSCR_ARMED:
      begin
        // A follower holds off until the preceding scan-done goes low
        if (start_s)
          s_d.start_seen = 1'b1;
        if (clk_fall && (lead_s || s_q.start_seen || start_s))
        begin
          s_d.mode = LSCR_RUN;
          s_d.hcnt = START_H;
        end
      end
      LSCR_RUN:
      begin
        if (clk_edge)
          s_d.hcnt = s_q.hcnt + 12'h0001;
        if (s_q.hcnt >= VID_START_H + SCAN_LEN_H + DONE_LEN_H)
          s_d.mode = LSCR_DONE;
      end
      LSCR_DONE:
      begin
      end
    endcase

    s_d.out.trig        = 1'b0;
    s_d.out.video_en    = 1'b0;
    s_d.out.scan_done_n = 1'b1;
    if (s_q.mode == LSCR_RUN)
    begin
      if (s_q.hcnt >= VID_START_H && rel < SCAN_LEN_H)
      begin
        s_d.out.video_en = (rel[2:0] < VID_LEN_H);
        s_d.out.trig     = (rel[2:0] >= TRIG_OFS_H) && (rel[2:0] < VID_LEN_H);
        // Second section numbers its channels from 129
        s_d.out.channel  = idx + 9'h001 + (sect_s ? SECOND_BASE : 9'h000);
      end
      // Before video start rel wraps high, so the count itself gates the pulse
      else if (s_q.hcnt >= VID_START_H && rel < SCAN_LEN_H + DONE_LEN_H)
        s_d.out.scan_done_n = 1'b0;
    end

    // Reset pin high aborts any scan; video goes undriven
    if (rst_s)
    begin
      s_d.mode            = LSCR_IDLE;
      s_d.hcnt            = 12'h0000;
      s_d.out.trig        = 1'b0;
      s_d.out.video_en    = 1'b0;
      s_d.out.scan_done_n = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_q.mode            <= LSCR_IDLE;
      s_q.hcnt            <= 12'h0000;
      s_q.clk_prev        <= 1'b0;
      s_q.start_seen      <= 1'b0;
      s_q.out.trig        <= 1'b0;
      s_q.out.scan_done_n <= 1'b1;
      s_q.out.video_en    <= 1'b0;
      s_q.out.channel     <= 9'h000;
      s_q.out.feedback_cap <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  assign trig         = s_q.out.trig;
  assign scan_done_n  = s_q.out.scan_done_n;
  assign video_en     = s_q.out.video_en;
  assign channel      = s_q.out.channel;
  assign feedback_cap = s_q.out.feedback_cap;

endmodule : lscr_top

/* testbench/lscr_ctl_model.sv */
// Readout controller model: shared sensor clock and reset pulse
`timescale 1ns/1ns
module lscr_ctl_model
(
  input  wire logic mclk,       // System clock
  output logic      sensor_clk, // Shared sensor clock
  output logic      sensor_rst  // Shared reset pulse
);
  initial sensor_clk = 1'b0;
  initial sensor_rst = 1'b0;
  // Clock stands low between frames; 8 mclk per sensor clock
  task automatic cycles(input int n, input logic r);
    repeat (n)
    begin
      @(posedge mclk);
      sensor_clk <= 1'b1;
      sensor_rst <= r;
      repeat (4) @(posedge mclk);
      sensor_clk <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask : cycles
  task automatic frame();
    cycles(21, 1'b1);
    cycles(1100, 1'b0);
  endtask : frame
endmodule : lscr_ctl_model

/* testbench/lscr_top_checker.sv */
// Port checks for one readout section
`timescale 1ns/1ns
module lscr_top_checker
  import lscr_pkg::*;
(
  input logic       mclk,        // Clock
  input logic       sys_rst,     // Reset
  input logic       gain_sel,    // Gain strap
  input logic       trig,        // Trigger
  input logic       scan_done_n, // End of scan
  input logic       video_en,    // Video valid
  input logic [8:0] channel,     // Channel
  input logic       feedback_cap // Cap select
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_cap_follows: assert property ($stable(gain_sel) [*5] |-> feedback_cap == gain_sel)
    else $error("cap mismatch");
  a_trig_in_video: assert property (trig |-> video_en)
    else $error("trig outside video");
  a_video_long: assert property ($rose(video_en) |-> video_en [*8])
    else $error("video too short");
  a_trig_ends: assert property ($fell(trig) |-> $fell(video_en))
    else $error("trig end off");
  a_chan_next: assert property ($rose(video_en) |->
    channel == $past(channel) + 9'h001 || channel inside {9'h001, 9'h081})
    else $error("channel order");
  a_done_last: assert property ($fell(scan_done_n) |-> channel inside {9'h080, 9'h100})
    else $error("done early");
  a_done_width: assert property ($fell(scan_done_n) |-> !scan_done_n [*5])
    else $error("done too short");
  a_done_quiet: assert property (!scan_done_n |-> !video_en && !trig)
    else $error("video in done");
endmodule : lscr_top_checker
bind lscr_top lscr_top_checker chk (.mclk(mclk), .sys_rst(sys_rst), .gain_sel(gain_sel),
  .trig(trig), .scan_done_n(scan_done_n), .video_en(video_en), .channel(channel),
  .feedback_cap(feedback_cap));

/* testbench/tb_line_sensor_chain_readout.sv */
// Two sections read out serially, then in parallel
`timescale 1ns/1ns
module tb_line_sensor_chain_readout;
  logic       mclk = 1'b0, sys_rst = 1'b1, gain = 1'b0, lead_b = 1'b0, pa = 1'b0, pb = 1'b0;
  logic       sclk, srst, t_a, t_b, d_a, d_b, v_a, v_b, f_a, f_b;
  logic [8:0] ch_a, ch_b;
  int         errors = 0, comparisons = 0, n_a, n_b;
  time        t0;
  initial forever #2 mclk = ~mclk;
  lscr_ctl_model ctl (.mclk(mclk), .sensor_clk(sclk), .sensor_rst(srst));
  lscr_top uut (.mclk(mclk), .sys_rst(sys_rst), .sensor_clk(sclk), .sensor_rst(srst),
    .ext_start_in(1'b1), .lead_sel(1'b1), .second_section(1'b0), .gain_sel(gain),
    .trig(t_a), .scan_done_n(d_a), .video_en(v_a), .channel(ch_a), .feedback_cap(f_a));
  // Follower start comes from the leader's end of scan unless both lead
  lscr_top uut2 (.mclk(mclk), .sys_rst(sys_rst), .sensor_clk(sclk), .sensor_rst(srst),
    .ext_start_in(lead_b | d_a), .lead_sel(lead_b), .second_section(1'b1), .gain_sel(gain),
    .trig(t_b), .scan_done_n(d_b), .video_en(v_b), .channel(ch_b), .feedback_cap(f_b));
  task automatic check(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : check
  task automatic summarize();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  always @(negedge srst)
    t0 = $time;
  always @(posedge mclk)
  begin
    pa <= t_a;
    pb <= t_b;
    if (t_a === 1'b1 && pa === 1'b0)
    begin
      n_a++;
      check(ch_a === 9'(n_a), "leader channel");
      if (n_a == 1)
        check($time - t0 inside {[608:632]}, "first trig time");
    end
    if (t_b === 1'b1 && pb === 1'b0)
    begin
      n_b++;
      check(ch_b === 9'(128 + n_b), "second channel");
      check(lead_b ? n_a == n_b : n_a == 128, "section order");
    end
    check(sys_rst || lead_b || !(v_a && v_b), "video clash");
  end
  task automatic run_frame(input logic par, input logic g);
    gain <= g;
    lead_b <= par;
    n_a = 0;
    n_b = 0;
    ctl.cycles(3, 1'b0);
    ctl.frame();
    check(n_a == 128 && n_b == 128, "channel count");
    check(f_a === g && f_b === g, "gain cap");
    $display("Frame done, parallel %0b", par);
  endtask : run_frame
  initial
  begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    run_frame(1'b0, 1'b1);
    run_frame(1'b1, 1'b0);
    summarize();
  end
  initial
  begin
    repeat (40000) @(posedge mclk);
    errors++;
    summarize();
  end
endmodule : tb_line_sensor_chain_readout
